// *** src/error_sync_barrier_pkg.sv ***
package error_sync_barrier_pkg;

    // Syndrome width: holds any value hardware reports on a physical error
    localparam int SYND_W = 25;
    // Width of the count of outstanding memory-system responses
    localparam int OUTST_W = 4;

    // Severity codes kept in the syndrome severity field
    localparam logic [1:0] SEV_UC = 2'h0;
    localparam logic [1:0] SEV_UEU = 2'h1;
    localparam logic [1:0] SEV_UEO = 2'h2;
    localparam logic [1:0] SEV_UER = 2'h3;

    // Severity field position inside the syndrome
    localparam int SEV_LSB = 10;
    localparam int SEV_MSB = 11;

    // Precise-report bit position inside the syndrome
    localparam int PRECISE_BIT = 9;

    // Syndrome bits that this core keeps; bits outside this mask read as zero
    localparam logic [SYND_W-1:0] SYND_KEEP_MASK = 25'h1FFFFFF;
    // Syndrome bits that this core always sets on a physical error entry
    localparam logic [SYND_W-1:0] SYND_ONE_MASK = 25'h0000000;

    // Register offsets on the software port
    localparam logic [3:0] OFF_DEFERRED = 4'h0;
    localparam logic [3:0] OFF_VDEFERRED = 4'h1;
    localparam logic [3:0] OFF_VSYND = 4'h2;
    localparam logic [3:0] OFF_CTRL = 4'h3;
    localparam logic [3:0] OFF_IRQ_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ_MASK = 4'h5;

    // Control register field positions
    localparam int CTRL_ROUTE_BIT = 0;
    localparam int CTRL_TRAP_BIT = 1;
    localparam int CTRL_HYP_EN_BIT = 2;
    localparam int CTRL_VPEND_BIT = 3;

    // Interrupt status bits
    localparam int IRQ_W = 3;
    localparam int IRQ_PDEFER = 0;
    localparam int IRQ_VDEFER = 1;
    localparam int IRQ_TAKEN = 2;

    // Exception levels as seen by the barrier
    localparam logic [1:0] LEVEL_APP = 2'h0;
    localparam logic [1:0] LEVEL_KERNEL = 2'h1;

    // Barrier sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DRAIN = 3'b010,
        ST_RESOLVE = 3'b100
    } barrier_state_t;

endpackage

// *** src/error_sync_barrier_unit.sv ***
// Behaviour
// RULE1: Unmasked physical error taken at barrier address
// RULE2: Masked physical error deferred, recorded, valid set
// RULE3: Earlier unrecoverable errors pend before barrier acts
// RULE4: Later errors neither recorded nor taken here
// RULE5: Covers fetch, walk, update and instruction errors
// RULE6: Synchronized error reported as unrecoverable severity
// RULE7: Uncontainable error may stay pending after barrier
// RULE8: Unconsumed errors taken or deferred report precise
// RULE9: Virtual sync at low levels, routing on, trap off
// RULE10: Unmasked virtual error taken before barrier completes
// RULE11: Masked virtual error clears pending, records, valid
// RULE12: Virtual sync runs alongside physical barrier
// RULE13: Deferred register privileged; routed to virtual copy
// RULE14: Valid flag constant zero when sync disabled
// RULE15: Syndrome registers hold every reportable syndrome
// RULE16: Unused zero syndrome bits hardwired zero
// RULE17: Constant syndrome bits hardwired in other registers
// RULE18: Complete only after earlier error responses return
//
// Strobed register access and the address map were decided locally.
module error_sync_barrier_unit
    import error_sync_barrier_pkg::*;
#(
    parameter bit SYNC_ENABLE = 1'b1,
    parameter bit TAKE_UNCONTAINABLE = 1'b0
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Barrier request from the pipeline
    input wire logic barrier_valid,
    input wire logic [31:0] barrier_addr,
    input wire logic [1:0] current_level,
    input wire logic non_secure,
    input wire logic serr_masked,
    input wire logic vserr_masked,
    output logic barrier_done,
    // Error exception request to the pipeline
    output logic take_serr,
    output logic take_vserr,
    output logic [31:0] return_addr,
    output logic [SYND_W-1:0] exception_syndrome,
    // Memory-system error sources, all on this processing element
    input wire logic mem_req_issue,
    input wire logic mem_resp_return,
    input wire logic err_valid,
    input wire logic [SYND_W-1:0] err_syndrome,
    input wire logic err_uncontainable,
    input wire logic err_consumed,
    output logic serr_pending,
    // Software register port; only OFF_DEFERRED checks the privilege level
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic irq
);

    // Barrier sequencer
    barrier_state_t state_reg, state_next;
    // Outstanding memory responses
    logic [OUTST_W-1:0] outst_reg;
    // Physical pending error and its attributes
    logic pend_reg;
    logic pend_uc_reg;
    logic [SYND_W-1:0] pend_synd_reg;
    // Deferred registers
    logic def_valid_reg;
    logic [SYND_W-1:0] def_synd_reg;
    logic vdef_valid_reg;
    logic [SYND_W-1:0] vdef_synd_reg;
    logic [SYND_W-1:0] vsynd_reg;
    // Virtual controls
    logic route_reg, trap_reg, hyp_en_reg, vpend_reg;
    // Interrupt status and mask
    logic [IRQ_W-1:0] irq_status_reg, irq_mask_reg;
    // Barrier capture
    logic [31:0] baddr_reg;
    logic bmask_reg, bvmask_reg, blow_reg;
    // Outputs from flops
    logic done_reg, take_reg, vtake_reg;
    logic [SYND_W-1:0] esynd_reg;
    logic [31:0] rdata_reg;

    // Syndrome shaping: clamp never-used bits, force always-one bits
    function automatic logic [SYND_W-1:0] shape(input logic [SYND_W-1:0] s);
        shape = (s & SYND_KEEP_MASK) | SYND_ONE_MASK;
    endfunction

    // Syndrome reported at the barrier: unrecoverable, or uncontainable when uc is set; precise
    function automatic logic [SYND_W-1:0] report(input logic [SYND_W-1:0] s,
                                                 input logic uc);
        logic [SYND_W-1:0] r;
        r = s;
        r[SEV_MSB:SEV_LSB] = uc ? SEV_UC : SEV_UEU;
        r[PRECISE_BIT] = 1'b1;
        report = shape(r);
    endfunction

    // Decode of the software port
    wire privileged = current_level != LEVEL_APP;
    wire redirect = hyp_en_reg && route_reg && non_secure && current_level == LEVEL_KERNEL;
    wire wr_def = reg_write && privileged && reg_addr == OFF_DEFERRED && !redirect;
    wire wr_vdef = reg_write && ((privileged && reg_addr == OFF_DEFERRED && redirect)
                                 || reg_addr == OFF_VDEFERRED);
    wire wr_vsynd = reg_write && reg_addr == OFF_VSYND;
    wire wr_ctrl = reg_write && reg_addr == OFF_CTRL;
    wire wr_istat = reg_write && reg_addr == OFF_IRQ_STATUS;
    wire wr_imask = reg_write && reg_addr == OFF_IRQ_MASK;

    // Drain done: every earlier response folded into pending state
    wire drained = outst_reg == '0 && !mem_resp_return;
    // Virtual sync eligibility, captured at barrier start
    wire vsync_ok = hyp_en_reg && route_reg && !trap_reg
                    && (current_level == LEVEL_APP || current_level == LEVEL_KERNEL);
    // Physical pending error includes one arriving in the resolve cycle's past
    wire resolving = state_reg == ST_RESOLVE;
    // Uncontainable errors are left pending unless configured to synchronize
    wire psync = pend_reg && (!pend_uc_reg || TAKE_UNCONTAINABLE);
    wire p_take = resolving && psync && !bmask_reg;
    wire p_defer = resolving && psync && bmask_reg && SYNC_ENABLE;
    wire v_act = resolving && blow_reg && vpend_reg;
    wire v_take = v_act && !bvmask_reg;
    wire v_defer = v_act && bvmask_reg && SYNC_ENABLE;

    // Read mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = '0;
        unique case (reg_addr)
            OFF_DEFERRED: begin
                if (!privileged) begin
                    rd_mux = '0;
                end else if (redirect) begin
                    rd_mux = {vdef_valid_reg, 6'h00, vdef_synd_reg};
                end else begin
                    rd_mux = {def_valid_reg, 6'h00, def_synd_reg};
                end
            end
            OFF_VDEFERRED: rd_mux = {vdef_valid_reg, 6'h00, vdef_synd_reg};
            OFF_VSYND: rd_mux = {7'h00, vsynd_reg};
            OFF_CTRL: rd_mux = {28'h0000000, vpend_reg, hyp_en_reg, trap_reg, route_reg};
            OFF_IRQ_STATUS: rd_mux = {29'h00000000, irq_status_reg};
            OFF_IRQ_MASK: rd_mux = {29'h00000000, irq_mask_reg};
            default: rd_mux = '0;
        endcase
    end

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: if (barrier_valid) state_next = ST_DRAIN;
            // RULE3: wait for errors to pend
            ST_DRAIN: if (drained) state_next = ST_RESOLVE;
            ST_RESOLVE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // Sequencer and barrier capture
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            baddr_reg <= '0;
            bmask_reg <= 1'b0;
            bvmask_reg <= 1'b0;
            blow_reg <= 1'b0;
        end else if (clk_en) begin
            state_reg <= state_next;
            if (state_reg == ST_IDLE && barrier_valid) begin
                baddr_reg <= barrier_addr;
                bmask_reg <= serr_masked;
                bvmask_reg <= vserr_masked;
                // RULE9: virtual sync conditions
                blow_reg <= vsync_ok;
            end
        end
    end

    // Outstanding response count
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            outst_reg <= '0;
        end else if (clk_en) begin
            // RULE18: track earlier responses
            if (mem_req_issue && !mem_resp_return) begin
                outst_reg <= outst_reg + 1'b1;
            end else if (!mem_req_issue && mem_resp_return && outst_reg != '0) begin
                outst_reg <= outst_reg - 1'b1;
            end
        end
    end

    // Physical pending error; a new error wins over the barrier's clear
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pend_reg <= 1'b0;
            pend_uc_reg <= 1'b0;
            pend_synd_reg <= '0;
        end else if (clk_en) begin
            // RULE5: any error source of this element
            if (err_valid) begin
                pend_reg <= 1'b1;
                pend_uc_reg <= pend_uc_reg | err_uncontainable;
                // RULE8: unconsumed errors marked precise
                pend_synd_reg <= err_consumed ? err_syndrome
                                 : (err_syndrome | (25'h0000001 << PRECISE_BIT));
            // RULE7: uncontainable stays pending
            end else if (p_take || p_defer) begin
                pend_reg <= 1'b0;
                pend_uc_reg <= 1'b0;
            end
        end
    end

    // Deferred registers, virtual syndrome and controls
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            def_valid_reg <= 1'b0;
            def_synd_reg <= '0;
            vdef_valid_reg <= 1'b0;
            vdef_synd_reg <= '0;
            vsynd_reg <= '0;
            route_reg <= 1'b0;
            trap_reg <= 1'b0;
            hyp_en_reg <= 1'b0;
            vpend_reg <= 1'b0;
        end else if (clk_en) begin
            // RULE2: record deferred physical error
            // RULE4: only errors pended before the resolve cycle
            if (p_defer) begin
                def_valid_reg <= 1'b1;
                // RULE6: unrecoverable severity recorded, uncontainable when pend_uc_reg is set
                def_synd_reg <= report(pend_synd_reg, pend_uc_reg);
            end else if (wr_def) begin
                // RULE14: valid stays zero when sync disabled
                def_valid_reg <= reg_wdata[31] && SYNC_ENABLE;
                // RULE16: unused bits forced
                def_synd_reg <= shape(reg_wdata[SYND_W-1:0]);
            end
            // RULE11: record deferred virtual error
            // RULE12: same cycle as the physical resolve
            if (v_defer) begin
                vdef_valid_reg <= 1'b1;
                vdef_synd_reg <= vsynd_reg;
            // RULE13: redirected writes land here
            end else if (wr_vdef) begin
                vdef_valid_reg <= reg_wdata[31] && SYNC_ENABLE;
                vdef_synd_reg <= shape(reg_wdata[SYND_W-1:0]);
            end
            // RULE17: constant bits hardwired in virtual syndrome
            if (wr_vsynd) vsynd_reg <= shape(reg_wdata[SYND_W-1:0]);
            if (wr_ctrl) begin
                route_reg <= reg_wdata[CTRL_ROUTE_BIT];
                trap_reg <= reg_wdata[CTRL_TRAP_BIT];
                hyp_en_reg <= reg_wdata[CTRL_HYP_EN_BIT];
            end
            // Barrier clear loses to a software set in the same cycle
            if (wr_ctrl && reg_wdata[CTRL_VPEND_BIT]) begin
                vpend_reg <= 1'b1;
            end else if (wr_ctrl) begin
                vpend_reg <= 1'b0;
            end else if (v_take || v_defer) begin
                vpend_reg <= 1'b0;
            end
        end
    end

    // Exception requests and completion
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            done_reg <= 1'b0;
            take_reg <= 1'b0;
            vtake_reg <= 1'b0;
            esynd_reg <= '0;
            rdata_reg <= '0;
        end else if (clk_en) begin
            done_reg <= resolving;
            // RULE1: take at barrier address
            take_reg <= p_take;
            // RULE10: virtual take before completion
            vtake_reg <= v_take;
            if (p_take) begin
                // RULE15: full width syndrome
                esynd_reg <= report(pend_synd_reg, pend_uc_reg);
            end else if (v_take) begin
                esynd_reg <= vsynd_reg;
            end
            rdata_reg <= reg_read ? rd_mux : '0;
        end
    end

    // Interrupt status: hardware set wins over write-one clear
    wire [IRQ_W-1:0] irq_set = {p_take, v_defer, p_defer};
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_status_reg <= '0;
            irq_mask_reg <= '0;
        end else if (clk_en) begin
            irq_status_reg <= (irq_status_reg & ~(wr_istat ? reg_wdata[IRQ_W-1:0] : '0))
                              | irq_set;
            if (wr_imask) irq_mask_reg <= reg_wdata[IRQ_W-1:0];
        end
    end

    assign barrier_done = done_reg;
    assign take_serr = take_reg;
    assign take_vserr = vtake_reg;
    assign return_addr = baddr_reg;
    assign exception_syndrome = esynd_reg;
    assign serr_pending = pend_reg;
    assign reg_rdata = rdata_reg;
    assign irq = |(irq_status_reg & irq_mask_reg);

endmodule

// *** tb/error_sync_barrier_properties.sv ***
module error_sync_barrier_checker
    import error_sync_barrier_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic barrier_valid,
    input wire logic [31:0] barrier_addr,
    input wire logic serr_masked,
    input wire logic barrier_done,
    input wire logic take_serr,
    input wire logic take_vserr,
    input wire logic [31:0] return_addr,
    input wire logic [SYND_W-1:0] exception_syndrome,
    input wire logic mem_req_issue,
    input wire logic mem_resp_return
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Barrier in flight and what it sampled at its start
    logic busy_h;
    logic mask_h;
    logic [31:0] addr_h;
    // Memory responses still owed to the core
    logic [7:0] outst_h;
    // Accepted when idle, or in the very cycle the previous one completes
    wire start_w = clk_en && barrier_valid && (!busy_h || barrier_done);
    // Track barrier and outstanding count; frozen with the core when clk_en is low
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_h <= 1'b0;
            mask_h <= 1'b0;
            addr_h <= 32'h00000000;
            outst_h <= 8'h00;
        end else if (clk_en) begin
            busy_h <= start_w || (busy_h && !barrier_done);
            outst_h <= outst_h + 8'(mem_req_issue) - 8'(mem_resp_return);
            if (start_w) begin
                mask_h <= serr_masked;
                addr_h <= barrier_addr;
            end
        end
    end
    property p_take_addr;
        take_serr |-> return_addr == addr_h;
    endproperty
    a_take_addr: assert property (p_take_addr) else $error("bad return address");
    property p_take_done;
        take_serr |-> barrier_done;
    endproperty
    a_take_done: assert property (p_take_done) else $error("take outside completion");
    property p_vtake_done;
        take_vserr |-> barrier_done;
    endproperty
    a_vtake_done: assert property (p_vtake_done) else $error("virtual take late");
    property p_take_unmasked;
        take_serr |-> !mask_h;
    endproperty
    a_take_unmasked: assert property (p_take_unmasked) else $error("masked error taken");
    property p_sev;
        take_serr |-> exception_syndrome[SEV_MSB:SEV_LSB] == SEV_UEU
            && exception_syndrome[PRECISE_BIT];
    endproperty
    a_sev: assert property (p_sev) else $error("bad severity or precise bit");
    property p_done_bound;
        start_w |-> ##[2:60] barrier_done;
    endproperty
    a_done_bound: assert property (p_done_bound) else $error("barrier never done");
    property p_done_pulse;
        barrier_done |=> !barrier_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_drained;
        barrier_done |-> outst_h == 8'h00;
    endproperty
    a_drained: assert property (p_drained) else $error("done before drain");
endmodule

bind error_sync_barrier_unit error_sync_barrier_checker chk (
    .sys_clk, .nrst, .clk_en, .barrier_valid, .barrier_addr, .serr_masked,
    .barrier_done, .take_serr, .take_vserr, .return_addr, .exception_syndrome,
    .mem_req_issue, .mem_resp_return
);

// *** tb/error_source_model.sv ***
module error_source_model
    import error_sync_barrier_pkg::*;
(
    input wire logic sys_clk,
    input wire logic go,
    input wire logic [2:0] kind,
    input wire logic [SYND_W-1:0] synd,
    input wire logic [3:0] lat,
    output logic mem_req_issue = 1'b0,
    output logic mem_resp_return = 1'b0,
    output logic err_valid = 1'b0,
    output logic [SYND_W-1:0] err_syndrome = 25'h0000000,
    output logic err_uncontainable = 1'b0,
    output logic err_consumed = 1'b0
);
    timeunit 1ns;
    timeprecision 100ps;
    // Cycles left until the response comes back
    logic [3:0] cnt = 4'h0;
    wire fire = (cnt == 4'h1);
    // Request goes out, response returns lat cycles later
    always @(posedge sys_clk) begin
        mem_req_issue <= go;
        mem_resp_return <= fire;
        err_valid <= fire && kind[2];
        // Idle lines flip so a stale value never passes for data
        err_syndrome <= fire ? synd : ~err_syndrome;
        err_uncontainable <= fire ? kind[1] : ~err_uncontainable;
        err_consumed <= fire ? kind[0] : ~err_consumed;
        cnt <= go ? lat : cnt - 4'(cnt != 4'h0);
    end
endmodule

// *** tb/error_sync_barrier_unit_tb.sv ***
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end

module error_sync_barrier_unit_tb import error_sync_barrier_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic barrier_valid = 1'b0, non_secure = 1'b0, serr_masked = 1'b0, vserr_masked = 1'b0;
    logic reg_write = 1'b0, reg_read = 1'b0, go = 1'b0, clk_en = 1'b1;
    logic [1:0] current_level = 2'h1;
    logic [2:0] kind = 3'h0;
    logic [3:0] lat = 4'h1, reg_addr = 4'h0;
    logic [31:0] barrier_addr = 32'h00000000, reg_wdata = 32'h00000000;
    logic [31:0] rnd = 32'h00000024, m_def = 32'h00000000, m_vdef = 32'h00000000;
    logic [SYND_W-1:0] synd = 25'h0000000;
    logic barrier_done, take_serr, take_vserr, mem_req_issue, mem_resp_return, err_valid;
    logic err_uncontainable, err_consumed, serr_pending, irq;
    logic [31:0] return_addr, reg_rdata;
    logic [SYND_W-1:0] exception_syndrome, err_syndrome;
    // Syndromes pending in the model, oldest first
    logic [SYND_W-1:0] pend_q[$];
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    error_sync_barrier_unit dut (
        .sys_clk, .nrst, .clk_en, .barrier_valid, .barrier_addr, .current_level,
        .non_secure, .serr_masked, .vserr_masked, .barrier_done, .take_serr, .take_vserr,
        .return_addr, .exception_syndrome, .mem_req_issue, .mem_resp_return, .err_valid,
        .err_syndrome, .err_uncontainable, .err_consumed, .serr_pending, .reg_addr,
        .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq
    );
    error_source_model src (
        .sys_clk, .go, .kind, .synd, .lat, .mem_req_issue, .mem_resp_return, .err_valid,
        .err_syndrome, .err_uncontainable, .err_consumed
    );
    initial forever #12.5 sys_clk = ~sys_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Reported form: unrecoverable, precise, constant bits applied
    function automatic logic [SYND_W-1:0] rep(input logic [SYND_W-1:0] s);
        logic [SYND_W-1:0] r;
        r = s;
        r[SEV_MSB:SEV_LSB] = SEV_UEU;
        r[PRECISE_BIT] = 1'b1;
        return (r & SYND_KEEP_MASK) | SYND_ONE_MASK;
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_write <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_read <= 1'b0;
        #1;
        `CHK(reg_rdata, e)
    endtask
    // One memory access; kind bit 2 error, bit 1 uncontainable, bit 0 consumed
    task automatic mem_op(input logic [2:0] k, input logic [SYND_W-1:0] s);
        @(posedge sys_clk);
        go <= 1'b1;
        kind <= k;
        synd <= s;
        lat <= {1'b0, rnd[2:0]} + 4'h1;
        @(posedge sys_clk);
        go <= 1'b0;
        @(posedge sys_clk);
    endtask
    // Run one barrier and compare its completion with the model
    task automatic barrier(input logic [1:0] lv, input logic m, input logic vm,
                           input logic et, input logic ev, input logic [SYND_W-1:0] es);
        int n;
        @(posedge sys_clk);
        barrier_valid <= 1'b1;
        barrier_addr <= rnd;
        current_level <= lv;
        serr_masked <= m;
        vserr_masked <= vm;
        @(posedge sys_clk);
        barrier_valid <= 1'b0;
        #1;
        for (n = 0; n < 60 && barrier_done !== 1'b1; n++) begin
            @(posedge sys_clk);
            #1;
        end
        `CHK(barrier_done, 1'b1)
        `CHK(take_serr, et)
        `CHK(take_vserr, ev)
        if (et) `CHK(return_addr, rnd)
        if (et) `CHK(exception_syndrome, rep(es))
    endtask
    // Hang guard well above the expected few hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end
    initial begin
        logic [SYND_W-1:0] s;
        logic p;
        logic sy;
        logic [1:0] lv;
        logic [4:0] vt [6];
        int st;
        // Case code: level, routing, trap, virtual mask
        vt = '{5'h0D, 5'h0C, 5'h15, 5'h06, 5'h05, 5'h09};
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        reg_rd(OFF_DEFERRED, 32'h00000000);
        reg_rd(4'hF, 32'h00000000);
        `CHK(serr_pending, 1'b0)
        reg_wr(OFF_IRQ_MASK, 32'h00000001);
        p = 1'b0;
        st = 0;
        for (int i = 0; i < 12; i++) begin
            if (rnd[4] && !p) begin
                mem_op({2'h2, rnd[7]}, rnd[30:6]);
                pend_q.push_back(rnd[30:6]);
                p = 1'b1;
            end
            s = p ? pend_q.pop_front() : 25'h0000000;
            barrier(2'h1, rnd[5], 1'b1, p && !rnd[5], 1'b0, s);
            if (p && rnd[5]) m_def = {7'h40, rep(s)};
            st = st | (p ? (rnd[5] ? 1 : 4) : 0);
            p = 1'b0;
            `CHK(serr_pending, 1'b0)
            reg_rd(OFF_DEFERRED, m_def);
            `CHK(irq, st[0])
            if (i[0]) begin
                reg_rd(OFF_IRQ_STATUS, st);
                reg_wr(OFF_IRQ_STATUS, st);
                st = 0;
            end
            if (rnd[8] && i < 11) begin
                mem_op(3'h4, rnd[31:7]);
                for (int n = 0; n < 20 && serr_pending !== 1'b1; n++) @(posedge sys_clk);
                `CHK(serr_pending, 1'b1)
                reg_rd(OFF_DEFERRED, m_def);
                pend_q.push_back(rnd[31:7]);
                p = 1'b1;
            end
            rnd = lfsr(rnd);
        end
        foreach (vt[c]) begin
            lv = vt[c][4:3];
            sy = (lv <= LEVEL_KERNEL) && vt[c][2] && !vt[c][1];
            s = rnd[24:0];
            reg_wr(OFF_VSYND, {7'h00, s});
            // Stored form: constant syndrome bits applied
            s = (s & SYND_KEEP_MASK) | SYND_ONE_MASK;
            reg_rd(OFF_VSYND, {7'h00, s});
            reg_wr(OFF_CTRL, {28'h0000000, 2'h3, vt[c][1], vt[c][2]});
            mem_op(3'h4, rnd[31:7]);
            barrier(lv, 1'b1, vt[c][0], 1'b0, sy && !vt[c][0], 25'h0000000);
            if (sy && !vt[c][0]) `CHK(exception_syndrome, s)
            m_def = {7'h40, rep(rnd[31:7])};
            if (sy && vt[c][0]) m_vdef = {7'h40, s};
            reg_rd(OFF_DEFERRED, lv == LEVEL_APP ? 32'h00000000 : m_def);
            reg_rd(OFF_VDEFERRED, m_vdef);
            if (!sy || vt[c][0]) reg_rd(OFF_CTRL, {28'h0000000, !sy, 1'b1, vt[c][1], vt[c][2]});
            rnd = lfsr(rnd);
        end
        `CHK(irq, 1'b1)
        mem_op(3'h6, rnd[24:0]);
        barrier(2'h1, 1'b1, 1'b1, 1'b0, 1'b0, 25'h0000000);
        `CHK(serr_pending, 1'b1)
        reg_rd(OFF_DEFERRED, m_def);
        // Software write of all ones: valid is writable, syndrome keeps its width
        reg_wr(OFF_DEFERRED, 32'hFFFFFFFF);
        reg_rd(OFF_DEFERRED, {1'b1, 6'h00, SYND_KEEP_MASK | SYND_ONE_MASK});
        reg_wr(OFF_CTRL, 32'h00000005);
        non_secure <= 1'b1;
        reg_rd(OFF_DEFERRED, m_vdef);
        // Frozen core ignores a write, so the old mask must survive
        @(posedge sys_clk);
        clk_en <= 1'b0;
        reg_wr(OFF_IRQ_MASK, 32'h00000007);
        clk_en <= 1'b1;
        reg_rd(OFF_IRQ_MASK, 32'h00000001);
        stop_test();
    end
endmodule
